// File: design/dgs_pkg.sv
// Package of constants for the dual gate switching sequencer
package dgs_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets (plain register port, 4-bit address)
    localparam logic [3:0] DGS_ADDR_ENABLE   = 4'h0; // peripheral_enable_reg
    localparam logic [3:0] DGS_ADDR_PERIOD   = 4'h1; // period_register
    localparam logic [3:0] DGS_ADDR_MAXDUTY  = 4'h2; // max_duty_limit_reg
    localparam logic [3:0] DGS_ADDR_DEADTIME = 4'h3; // dead_time_reg
    localparam logic [3:0] DGS_ADDR_BLANK    = 4'h4; // leading_edge_blank_reg
    localparam logic [3:0] DGS_ADDR_DESATCTL = 4'h5; // desaturation_control_reg
    localparam logic [3:0] DGS_ADDR_STATUS   = 4'h6; // interrupt_flag_reg_two
    localparam logic [3:0] DGS_ADDR_MASK     = 4'h7; // interrupt mask
    localparam logic [3:0] DGS_ADDR_STATE    = 4'h8; // live sequencer state
    localparam logic [3:0] DGS_ADDR_TIMER    = 4'h9; // live period_timer value

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int DGS_EN_PRI_BIT   = 0; // primary driver enable
    localparam int DGS_EN_SEC_BIT   = 1; // secondary driver enable
    localparam int DGS_QR_BIT       = 0; // quasi_resonant_mode
    localparam int DGS_WDE_BIT      = 1; // desaturation_compare_watchdog_enable
    localparam int DGS_ST_OT_BIT    = 0; // overtemp_flag
    localparam int DGS_ST_TRIP_BIT  = 1; // peak current trip
    localparam int DGS_ST_CYC_BIT   = 2; // switching cycle started
    localparam int DGS_ST_WDOG_BIT  = 3; // watchdog restarted a cycle

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] DGS_RST_ENABLE   = 8'h00;
    localparam logic [7:0] DGS_RST_PERIOD   = 8'hFF;
    localparam logic [7:0] DGS_RST_MAXDUTY  = 8'h80;
    localparam logic [7:0] DGS_RST_DEADTIME = 8'h00;
    localparam logic [7:0] DGS_RST_BLANK    = 8'h00;
    localparam logic [7:0] DGS_RST_DESATCTL = 8'h00;
    localparam logic [7:0] DGS_RST_MASK     = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Timing: 125 MHz master clock, 8 MHz switching base
    localparam int MCLK_PERIOD_NS = 8;
    localparam int MCLK_MHZ       = 125;
    localparam int BASE_MHZ       = 8;
    localparam logic [7:0] DGS_ACC_STEP = 8'(BASE_MHZ);
    localparam logic [7:0] DGS_ACC_MOD  = 8'(MCLK_MHZ);
    localparam logic [7:0] DGS_PR_MIN   = 8'h03; // N = PR + 1 >= 4
    localparam int RESET_OS_NS  = 200;
    localparam int START_OS_NS  = 33;
    localparam int DEAD_STEP_NS = 16;
    localparam int LEB1_NS      = 50;
    localparam int LEB2_NS      = 100;
    localparam int LEB3_NS      = 200;
    // Least times, rounded up to whole cycles
    localparam logic [4:0] RESET_OS_CYC  = 5'((RESET_OS_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);
    localparam logic [4:0] START_OS_CYC  = 5'((START_OS_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);
    localparam logic [5:0] DEAD_STEP_CYC = 6'((DEAD_STEP_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);
    localparam logic [4:0] LEB1_CYC      = 5'((LEB1_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);
    localparam logic [4:0] LEB2_CYC      = 5'((LEB2_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);
    localparam logic [4:0] LEB3_CYC      = 5'((LEB3_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);

    // Sequencer states
    typedef enum logic [2:0] {
        DGS_IDLE,
        DGS_DEAD_P,
        DGS_PRI_ON,
        DGS_DEAD_S,
        DGS_SEC_ON
    } dgs_state_e;

endpackage

// File: design/dgs_sequencer.sv
// Dual gate switching sequencer with register port and interrupt
`timescale 1ns/1ps
module dgs_sequencer
    import dgs_pkg::*;
(
    // Clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_reset_n,
    // Register port
    input  wire logic [3:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    // Analog comparator inputs
    input  wire logic       i_peak_trip,
    input  wire logic       i_desaturation_compare,
    input  wire logic       i_overtemp,
    // Gate drives and interrupt
    output logic            o_primary_gate_out,
    output logic            o_secondary_gate_out,
    output logic            o_irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers and next values
    dgs_state_e state_r, state_nxt;         // Sequencer state
    logic [7:0] enable_r, enable_nxt;       // peripheral_enable_reg
    logic [7:0] period_r, period_nxt;       // period_register
    logic [7:0] maxduty_r, maxduty_nxt;     // max_duty_limit_reg
    logic [7:0] dead_r, dead_nxt;           // dead_time_reg
    logic [7:0] blank_r, blank_nxt;         // leading_edge_blank_reg
    logic [7:0] dctl_r, dctl_nxt;           // desaturation_control_reg
    logic [7:0] status_r, status_nxt;       // Sticky event flags
    logic [7:0] mask_r, mask_nxt;           // Interrupt mask
    logic [7:0] rdata_r, rdata_nxt;         // Read data
    logic [7:0] acc_r, acc_nxt;             // 8 MHz phase accumulator
    logic [7:0] timer_r, timer_nxt;         // period_timer
    logic [7:0] on_r, on_nxt;               // Primary on-time in base ticks
    logic [5:0] dcnt_r, dcnt_nxt;           // Dead time countdown
    logic [4:0] bcnt_r, bcnt_nxt;           // Blanking countdown
    logic [4:0] ros_r, ros_nxt;             // 200 ns reset one-shot
    logic [4:0] sos_r, sos_nxt;             // 33 ns start one-shot
    logic       cyc_ff_r, cyc_ff_nxt;       // Cycle flip-flop
    logic       dprev_r, dprev_nxt;         // Previous comparator level
    logic       pri_r, pri_nxt;             // Primary gate flop
    logic       sec_r, sec_nxt;             // Secondary gate flop

    // Combinational helpers
    logic [7:0] acc_sum;
    logic       tick;
    logic [7:0] pr_eff;
    logic       period_wrap;
    logic       qr_mode;
    logic       wd_en;
    logic       desaturation_compare_fall;
    logic       run;
    logic       cycle_start;
    logic       wdog_start;
    logic       trip_hit;
    logic       duty_hit;
    logic       fire_reset;
    logic [5:0] dead_len;
    logic [4:0] leb_len;
    logic [7:0] events;

    ////////////////////////////////////////////////////////////////////////////
    // Next-value logic for the whole block
    always_comb begin
        // 8 MHz base tick from a phase accumulator, one master edge per tick
        acc_sum = acc_r + DGS_ACC_STEP;
        tick    = (acc_sum >= DGS_ACC_MOD);
        acc_nxt = tick ? (acc_sum - DGS_ACC_MOD) : acc_sum;

        // Period N = PR + 1, clamped to 4..256
        pr_eff      = (period_r < DGS_PR_MIN) ? DGS_PR_MIN : period_r;
        period_wrap = tick && (timer_r >= pr_eff);

        qr_mode = dctl_r[DGS_QR_BIT];
        wd_en   = dctl_r[DGS_WDE_BIT];
        run     = (enable_r[DGS_EN_PRI_BIT] || enable_r[DGS_EN_SEC_BIT])
                  && !i_overtemp;

        // Comparator fall counts only in QR mode and outside the noise mask
        desaturation_compare_fall = qr_mode && dprev_r && !i_desaturation_compare
                     && (ros_r == 5'h00);
        wdog_start = qr_mode && wd_en && period_wrap;
        cycle_start = run && ((!qr_mode && period_wrap)
                              || desaturation_compare_fall || wdog_start);

        dead_len = (6'(dead_r[3:0]) + 6'h01) * DEAD_STEP_CYC;
        unique case (blank_r[1:0])
            2'h0:    leb_len = 5'h00;
            2'h1:    leb_len = LEB1_CYC;
            2'h2:    leb_len = LEB2_CYC;
            default: leb_len = LEB3_CYC;
        endcase

        trip_hit = i_peak_trip && (bcnt_r == 5'h00);
        duty_hit = (on_r >= maxduty_r);

        // Sequencer defaults
        state_nxt  = state_r;
        dcnt_nxt   = (dcnt_r != 6'h00) ? dcnt_r - 6'h01 : 6'h00;
        bcnt_nxt   = (bcnt_r != 5'h00) ? bcnt_r - 5'h01 : 5'h00;
        on_nxt     = on_r;
        fire_reset = 1'b0;

        if (!run) begin
            // Disabled or overheated: park with both gates off
            state_nxt = DGS_IDLE;
        end else begin
            unique case (state_r)
                DGS_IDLE, DGS_SEC_ON: begin
                    if (cycle_start) begin
                        // Secondary drops first, then dead time
                        state_nxt = DGS_DEAD_P;
                        dcnt_nxt  = dead_len - 6'h01;
                    end
                end
                DGS_DEAD_P: begin
                    if (dcnt_r == 6'h00) begin
                        state_nxt = DGS_PRI_ON;
                        bcnt_nxt  = leb_len;
                        on_nxt    = 8'h00;
                    end
                end
                DGS_PRI_ON: begin
                    if (tick) begin
                        on_nxt = on_r + 8'h01;
                    end
                    // Trip or duty limit ends the on phase for this cycle
                    if (trip_hit || duty_hit) begin
                        state_nxt = DGS_DEAD_S;
                        dcnt_nxt  = dead_len - 6'h01;
                    end
                end
                DGS_DEAD_S: begin
                    if (dcnt_r == 6'h00) begin
                        state_nxt  = DGS_SEC_ON;
                        fire_reset = qr_mode;
                    end
                end
                default: state_nxt = DGS_IDLE;
            endcase
        end

        // One-shots: reset pulse masks noise, start pulse marks a new cycle
        ros_nxt = fire_reset ? RESET_OS_CYC
                : (ros_r != 5'h00) ? ros_r - 5'h01 : 5'h00;
        sos_nxt = desaturation_compare_fall ? START_OS_CYC
                : (sos_r != 5'h00) ? sos_r - 5'h01 : 5'h00;
        // Set has priority over clear on the cycle flip-flop
        if (desaturation_compare_fall) begin
            cyc_ff_nxt = 1'b1;
        end else if (fire_reset) begin
            cyc_ff_nxt = 1'b0;
        end else begin
            cyc_ff_nxt = cyc_ff_r;
        end
        dprev_nxt = i_desaturation_compare;

        // Period timer; only the reset one-shot clears it mid-period
        if (fire_reset) begin
            timer_nxt = 8'h00;
        end else if (tick) begin
            timer_nxt = period_wrap ? 8'h00 : timer_r + 8'h01;
        end else begin
            timer_nxt = timer_r;
        end

        // Gate flops gated by enables and overtemperature
        pri_nxt = (state_nxt == DGS_PRI_ON) && enable_r[DGS_EN_PRI_BIT]
                  && !i_overtemp;
        sec_nxt = (state_nxt == DGS_SEC_ON) && enable_r[DGS_EN_SEC_BIT]
                  && !i_overtemp;

        // Events; a new event beats the read that clears it
        events = 8'h00;
        events[DGS_ST_OT_BIT]   = i_overtemp;
        events[DGS_ST_TRIP_BIT] = (state_r == DGS_PRI_ON) && run && trip_hit;
        events[DGS_ST_CYC_BIT]  = cycle_start;
        events[DGS_ST_WDOG_BIT] = wdog_start && run;
        if (i_rd && (i_addr == DGS_ADDR_STATUS)) begin
            status_nxt = events;
        end else begin
            status_nxt = status_r | events;
        end

        // Register writes
        enable_nxt  = (i_wr && i_addr == DGS_ADDR_ENABLE)   ? i_wdata : enable_r;
        period_nxt  = (i_wr && i_addr == DGS_ADDR_PERIOD)   ? i_wdata : period_r;
        maxduty_nxt = (i_wr && i_addr == DGS_ADDR_MAXDUTY)  ? i_wdata : maxduty_r;
        dead_nxt    = (i_wr && i_addr == DGS_ADDR_DEADTIME) ? {4'h0, i_wdata[3:0]} : dead_r;
        blank_nxt   = (i_wr && i_addr == DGS_ADDR_BLANK)    ? {6'h00, i_wdata[1:0]} : blank_r;
        dctl_nxt    = (i_wr && i_addr == DGS_ADDR_DESATCTL) ? {6'h00, i_wdata[1:0]} : dctl_r;
        mask_nxt    = (i_wr && i_addr == DGS_ADDR_MASK)     ? {4'h0, i_wdata[3:0]} : mask_r;

        // Read mux; unmapped addresses read zero
        rdata_nxt = 8'h00;
        if (i_rd) begin
            unique case (i_addr)
                DGS_ADDR_ENABLE:   rdata_nxt = enable_r;
                DGS_ADDR_PERIOD:   rdata_nxt = period_r;
                DGS_ADDR_MAXDUTY:  rdata_nxt = maxduty_r;
                DGS_ADDR_DEADTIME: rdata_nxt = dead_r;
                DGS_ADDR_BLANK:    rdata_nxt = blank_r;
                DGS_ADDR_DESATCTL: rdata_nxt = dctl_r;
                DGS_ADDR_STATUS:   rdata_nxt = status_r;
                DGS_ADDR_MASK:     rdata_nxt = mask_r;
                DGS_ADDR_STATE:    rdata_nxt = {cyc_ff_r, (ros_r != 5'h00), (sos_r != 5'h00),
                                                sec_r, pri_r, 3'(state_r)};
                DGS_ADDR_TIMER:    rdata_nxt = timer_r;
                default:           rdata_nxt = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State registers; everything clears to a safe, gates-off value
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_r   <= DGS_IDLE;
            enable_r  <= DGS_RST_ENABLE;
            period_r  <= DGS_RST_PERIOD;
            maxduty_r <= DGS_RST_MAXDUTY;
            dead_r    <= DGS_RST_DEADTIME;
            blank_r   <= DGS_RST_BLANK;
            dctl_r    <= DGS_RST_DESATCTL;
            status_r  <= 8'h00;
            mask_r    <= DGS_RST_MASK;
            rdata_r   <= 8'h00;
            acc_r     <= 8'h00;
            timer_r   <= 8'h00;
            on_r      <= 8'h00;
            dcnt_r    <= 6'h00;
            bcnt_r    <= 5'h00;
            ros_r     <= 5'h00;
            sos_r     <= 5'h00;
            cyc_ff_r  <= 1'b0;
            dprev_r   <= 1'b0;
            pri_r     <= 1'b0;
            sec_r     <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            enable_r  <= enable_nxt;
            period_r  <= period_nxt;
            maxduty_r <= maxduty_nxt;
            dead_r    <= dead_nxt;
            blank_r   <= blank_nxt;
            dctl_r    <= dctl_nxt;
            status_r  <= status_nxt;
            mask_r    <= mask_nxt;
            rdata_r   <= rdata_nxt;
            acc_r     <= acc_nxt;
            timer_r   <= timer_nxt;
            on_r      <= on_nxt;
            dcnt_r    <= dcnt_nxt;
            bcnt_r    <= bcnt_nxt;
            ros_r     <= ros_nxt;
            sos_r     <= sos_nxt;
            cyc_ff_r  <= cyc_ff_nxt;
            dprev_r   <= dprev_nxt;
            pri_r     <= pri_nxt;
            sec_r     <= sec_nxt;
        end
    end

    // Gates and read data straight from flops; irq is a level decoded from the status and mask flops
    assign o_primary_gate_out   = pri_r;
    assign o_secondary_gate_out = sec_r;
    assign o_rdata              = rdata_r;
    assign o_irq                = |(status_r & mask_r);

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);

    sequence s_reset_fire;
        fire_reset;
    endsequence
    sequence s_reset_mask;
        (ros_r != 5'h00) [*8];
    endsequence

    a_no_overlap: assert property (!(pri_r && sec_r))
        else $error("both gates on together");
    a_deadtime_pri: assert property ($rose(pri_r) |-> $past(!sec_r, 2))
        else $error("primary rose without dead time");
    a_pri_enable: assert property (!enable_r[DGS_EN_PRI_BIT] |=> !pri_r)
        else $error("primary on while disabled");
    a_overtemp_off: assert property (i_overtemp |=> !pri_r && !sec_r && status_r[0])
        else $error("overtemp did not force gates off");
    a_trip_latch: assert property (state_r == DGS_PRI_ON && run && trip_hit
                                   |=> !pri_r [*2])
        else $error("primary not latched off after trip");
    a_blank_hold: assert property (state_r == DGS_PRI_ON && run && bcnt_r != 5'h00
                                   && !duty_hit |=> state_r == DGS_PRI_ON)
        else $error("peak trip not blanked");
    a_reset_pulse: assert property (s_reset_fire |=> (!cyc_ff_r && timer_r == 8'h00)
                                    ##0 s_reset_mask)
        else $error("reset one-shot wrong");
    a_desaturation_compare_masked: assert property (ros_r != 5'h00 && !fire_reset |=> $stable(sos_r)
                                     || sos_r < $past(sos_r))
        else $error("desaturation seen during mask");
    a_desaturation_compare_start: assert property (desaturation_compare_fall |=> cyc_ff_r && sos_r == START_OS_CYC)
        else $error("desaturation fall not handled");
    a_ff_wrap: assert property (!qr_mode && run && period_wrap && state_r == DGS_SEC_ON
                                |=> state_r == DGS_DEAD_P)
        else $error("period wrap did not start cycle");

endmodule

// File: sim/dgs_comparator_model.sv
// Behavioural peak-current and desaturation comparators facing the sequencer
`timescale 1ns/1ps
module dgs_comparator_model (
    // Clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_reset_n,
    // Gate drives seen by the power stage
    input  wire logic       i_pri,
    input  wire logic       i_sec,
    // Ramp lengths set by the bench
    input  wire logic [7:0] i_trip_dly,
    input  wire logic [7:0] i_desaturation_compare_dly,
    // Comparator outputs
    output logic            o_peak_trip,
    output logic            o_desaturation_compare
);
    logic [7:0] pri_cnt_r; // Cycles the primary has conducted
    logic [7:0] sec_cnt_r; // Cycles the secondary has conducted

    ////////////////////////////////////////////////////////////////////////////
    // Current ramps while primary is on; desaturation_compare falls when secondary energy is spent
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pri_cnt_r   <= 8'h00;
            sec_cnt_r   <= 8'h00;
            o_peak_trip <= 1'b0;
            o_desaturation_compare     <= 1'b1;
        end else begin
            pri_cnt_r   <= i_pri ? pri_cnt_r + 8'h01 : 8'h00;
            sec_cnt_r   <= i_sec ? sec_cnt_r + 8'h01 : 8'h00;
            // Trip is a level that holds until the primary lets go
            o_peak_trip <= i_pri && (pri_cnt_r >= i_trip_dly);
            // Magnetising current rebuilds while the primary conducts
            if (i_pri) begin
                o_desaturation_compare <= 1'b1;
            end else if (i_sec && (sec_cnt_r >= i_desaturation_compare_dly)) begin
                o_desaturation_compare <= 1'b0;
            end
        end
    end
endmodule

// File: sim/tb_dgs_sequencer.sv
// Self-checking bench for the dual gate switching sequencer
`timescale 1ns/1ps
module tb_dgs_sequencer;
    import dgs_pkg::*;
    logic       clk = 1'b0;
    logic       rst_n, wr, rd, ovt, trip, desaturation_compare, pri, sec, irq, pri_d;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, trip_dly, desaturation_compare_dly;
    int         bad_count = 0, check_count = 0, cyc = 0, last_rise = 0, per = 0;
    int         hi_len = 0, max_hi = 0, rises = 0, sec_lo = 0, gap_min = 999, sec_seen = 0;

    ////////////////////////////////////////////////////////////////////////////
    // 125 MHz clock
    always #4 clk = ~clk;
    dgs_sequencer DUT (.i_mclk(clk), .i_reset_n(rst_n), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_peak_trip(trip),
        .i_desaturation_compare(desaturation_compare), .i_overtemp(ovt), .o_primary_gate_out(pri),
        .o_secondary_gate_out(sec), .o_irq(irq));
    dgs_comparator_model u_cmp (.i_mclk(clk), .i_reset_n(rst_n), .i_pri(pri), .i_sec(sec),
        .i_trip_dly(trip_dly), .i_desaturation_compare_dly(desaturation_compare_dly), .o_peak_trip(trip), .o_desaturation_compare(desaturation_compare));

    ////////////////////////////////////////////////////////////////////////////
    // Gate monitor: edges, widths, dead gaps, overlap, run-time ceiling
    always @(posedge clk) begin
        cyc++;
        pri_d <= pri;
        if (pri === 1'b1 && pri_d === 1'b0) begin
            per = cyc - last_rise;
            last_rise = cyc;
            rises++;
            if (sec_lo < gap_min) gap_min = sec_lo;
        end
        hi_len = (pri === 1'b1) ? hi_len + 1 : 0;
        if (hi_len > max_hi) max_hi = hi_len;
        sec_lo = (sec === 1'b1) ? 0 : sec_lo + 1;
        if (sec === 1'b1) sec_seen = 1;
        if (pri === 1'b1 && sec === 1'b1) fail("gates overlap");
        if (cyc > 40000) begin
            fail("timeout");
            complete_run();
        end
    end

    task automatic fail(input string msg);
        bad_count++;
        $display("[FAIL] %0t %s", $time, msg);
    endtask
    task automatic check_reg(input logic [7:0] got, input logic [7:0] exp, input string w);
        check_count++;
        if (got !== exp) fail($sformatf("%s got %h exp %h", w, got, exp));
    endtask
    task automatic check_bit(input logic got, input logic exp, input string w);
        check_count++;
        if (got !== exp) fail($sformatf("%s got %b exp %b", w, got, exp));
    endtask
    task automatic check_rng(input int got, input int lo, input int hi, input string w);
        check_count++;
        if (got < lo || got > hi) fail($sformatf("%s got %0d want %0d..%0d", w, got, lo, hi));
    endtask
    // Register port: one-cycle strobes, read data in the following cycle
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        logic [7:0] v;
        reg_rd(a, v);
        check_reg(v & m, e, $sformatf("reg %h", a));
    endtask
    // Clear statistics off the sampling edge, after the last write has settled
    task automatic run(input int n);
        repeat (2) @(negedge clk);
        rises = 0;
        max_hi = 0;
        gap_min = 999;
        sec_seen = 0;
        repeat (n) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset;
        check_bit(pri, 1'b0, "pri after reset");
        check_bit(sec, 1'b0, "sec after reset");
        rd_chk(DGS_ADDR_ENABLE, 8'hFF, DGS_RST_ENABLE);
        rd_chk(DGS_ADDR_PERIOD, 8'hFF, DGS_RST_PERIOD);
        rd_chk(DGS_ADDR_MAXDUTY, 8'hFF, DGS_RST_MAXDUTY);
        rd_chk(DGS_ADDR_DEADTIME, 8'hFF, DGS_RST_DEADTIME);
        rd_chk(4'hF, 8'hFF, 8'h00);
        run(300);
        check_rng(rises, 0, 0, "no switching while disabled");
        $display("test reset done");
    endtask
    task automatic t_fixed;
        reg_wr(DGS_ADDR_PERIOD, 8'h07);
        reg_wr(DGS_ADDR_MAXDUTY, 8'h04);
        reg_wr(DGS_ADDR_DEADTIME, 8'h01);
        reg_wr(DGS_ADDR_ENABLE, 8'h03);
        run(520);
        check_rng(per, 124, 126, "period of 8 ticks");
        check_rng(max_hi, 5, 9, "trip ends on phase");
        check_rng(gap_min, 3, 6, "dead gap");
        check_bit(irq, 1'b0, "irq masked");
        rd_chk(DGS_ADDR_STATUS, 8'h02, 8'h02);
        reg_wr(DGS_ADDR_MASK, 8'h02);
        run(140);
        check_bit(irq, 1'b1, "irq unmasked");
        reg_wr(DGS_ADDR_MASK, 8'h00);
        $display("test fixed done");
    endtask
    task automatic t_blank_duty;
        int lo [4];
        lo = '{1, 7, 13, 25};
        trip_dly <= 8'h00;
        for (int i = 0; i < 4; i++) begin
            reg_wr(DGS_ADDR_BLANK, 8'(i));
            run(260);
            check_rng(max_hi, lo[i], lo[i] + 5, "blanking");
        end
        reg_wr(DGS_ADDR_BLANK, 8'h00);
        trip_dly <= 8'hC8;
        reg_wr(DGS_ADDR_MAXDUTY, 8'h02);
        run(300);
        check_rng(max_hi, 20, 34, "duty cap");
        reg_wr(DGS_ADDR_MAXDUTY, 8'h04);
        trip_dly <= 8'h05;
        $display("test blank and duty done");
    endtask
    task automatic t_enable;
        reg_wr(DGS_ADDR_ENABLE, 8'h01);
        run(300);
        check_rng(sec_seen, 0, 0, "secondary disabled");
        check_rng(rises, 2, 3, "primary still runs");
        reg_wr(DGS_ADDR_ENABLE, 8'h02);
        run(300);
        check_rng(rises, 0, 0, "primary disabled");
        reg_wr(DGS_ADDR_ENABLE, 8'h03);
        $display("test enable done");
    endtask
    task automatic t_overtemp;
        ovt <= 1'b1;
        repeat (3) @(posedge clk);
        check_bit(pri | sec, 1'b0, "gates forced off");
        run(300);
        check_rng(rises + sec_seen, 0, 0, "held off");
        rd_chk(DGS_ADDR_STATUS, 8'h01, 8'h01);
        reg_wr(DGS_ADDR_MASK, 8'h01);
        // Mask lands at the edge that ended the write; look once it has settled
        @(negedge clk);
        check_bit(irq, 1'b1, "overtemp irq");
        reg_wr(DGS_ADDR_MASK, 8'h00);
        ovt <= 1'b0;
        run(300);
        check_rng(rises, 2, 3, "resumes");
        $display("test overtemp done");
    endtask
    task automatic t_qr;
        desaturation_compare_dly <= 8'h28;
        // Switch modes mid on-phase, so a desaturation fall is still to come
        wait (pri === 1'b1);
        reg_wr(DGS_ADDR_PERIOD, 8'hFF);
        reg_wr(DGS_ADDR_DESATCTL, 8'h01);
        run(1000);
        check_rng(rises, 12, 24, "desaturation_compare paced cycles");
        desaturation_compare_dly <= 8'h0A;
        run(600);
        check_rng(rises, 0, 1, "fall in reset pulse ignored");
        rd_chk(DGS_ADDR_STATE, 8'hFF, 8'h14);
        reg_wr(DGS_ADDR_PERIOD, 8'h0F);
        reg_wr(DGS_ADDR_DESATCTL, 8'h03);
        run(1000);
        check_rng(rises, 2, 6, "watchdog restarts");
        rd_chk(DGS_ADDR_STATUS, 8'h08, 8'h08);
        $display("test quasi resonant done");
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst_n = 1'b0;
        {wr, rd, ovt} = 3'h0;
        addr = 4'h0;
        wdata = 8'h00;
        trip_dly = 8'h05;
        desaturation_compare_dly = 8'h02;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_fixed();
        t_blank_duty();
        t_enable();
        t_overtemp();
        t_qr();
        complete_run();
    end
endmodule
